// ==== design/socket_regs_pkg.sv ====
// Constants for the per-socket identity and interface status registers.
// Assumes a byte-wide register port inside the host clock domain.
package socket_regs_pkg;

    // =========================================================
    // Socket count and access offsets
    localparam int NUM_SOCKETS = 2;
    localparam logic [11:0] MEM_ID_OFS = 12'h800;
    localparam logic [11:0] MEM_STAT_OFS = 12'h801;
    localparam logic [7:0] IDX_ID_A = 8'h00;
    localparam logic [7:0] IDX_STAT_A = 8'h01;
    localparam logic [7:0] IDX_ID_B = 8'h40;
    localparam logic [7:0] IDX_STAT_B = 8'h41;
    localparam logic [3:0] IDX_HIGH_ZERO = 4'h0;

    // =========================================================
    // Identity register layout and reset values
    localparam int ID_TYPE_LSB = 6;
    localparam int ID_EMU_LSB = 4;
    localparam int ID_REV_LSB = 0;
    localparam logic [1:0] IFACE_TYPE_IO_MEM = 2'b10;
    localparam logic [1:0] ID_EMU_RESET = 2'b00;
    // Arbitrary revision codes, not tied to any real part
    localparam logic [3:0] ID_REV_RESET = 4'h5;
    localparam logic [3:0] ID_REV_LEGACY = 4'h3;

    // =========================================================
    // Interface status register layout
    localparam int STAT_RSVD_BIT = 7;
    localparam int STAT_POWER_BIT = 6;
    localparam int STAT_PINS_W = 6;
    localparam logic [1:0] STAT_TOP_RESET = 2'b00;

    // Sampled pin vector, in status bit order
    localparam int PIN_BVD1 = 0;
    localparam int PIN_BVD2 = 1;
    localparam int PIN_CD1 = 2;
    localparam int PIN_CD2 = 3;
    localparam int PIN_WP = 4;
    localparam int PIN_READY = 5;

    // Battery field codes for memory cards
    localparam logic [1:0] BATT_WARN = 2'b10;
    localparam logic [1:0] BATT_GOOD = 2'b11;

    // Register selection
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ID,
        SEL_STAT
    } reg_sel_t;

endpackage

// ==== design/socket_pin_sampler.sv ====
// Two-stage synchroniser for one socket's card status pins.
// Assumes the pins are asynchronous to i_ref_clk.
`timescale 1ns/1ps
`default_nettype none

module socket_pin_sampler #(
    parameter int WIDTH = 6
) (
    // Clock
    input wire logic i_ref_clk,
    // Raw pins, in status bit order
    input wire logic [WIDTH-1:0] i_pins,
    // Synchronised pins
    output logic [WIDTH-1:0] o_pins
);

    // =========================================================
    // Synchroniser
    // No reset here: status must track the pins even during reset
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_ref_clk) begin
        meta_r <= i_pins;
    end

    always_ff @(posedge i_ref_clk) begin
        sync_r <= meta_r;
    end

    assign o_pins = sync_r;

endmodule

`default_nettype wire

// ==== design/socket_id_status_regs.sv ====
// Identity and interface status registers for two card sockets.
// Assumes power state, card type and write unlock come from other
// registers on the same clock; card pins arrive asynchronously.
//
// Functional notes
// - Identity top bits fixed interface type 10b
// - Identity writes gated by unlock bit
// - Identity bits five, four are plain storage
// - Identity low nibble holds revision, resets to 5h
// - Writing legacy revision enters legacy mode
// - Status bit seven always reads zero
// - Status bit six shows socket power
// - Status bit five mirrors card ready
// - Status bit four mirrors write protect
// - Status bit three set when detect two low
// - Status bit two set when detect one low
// - Memory card: bits one, zero mirror battery pins
// - Battery field decodes dead, warning, good
// - I/O card: speaker, status-change pins shown raw
// - Socket copies at index 00/01 and 40/41
// - Also at 800/801 in socket memory space
// - Status low bits follow pins out of reset
`timescale 1ns/1ps
`default_nettype none

module socket_id_status_regs #(
    parameter int NUM_SOCKETS = socket_regs_pkg::NUM_SOCKETS,
    parameter logic [3:0] REV_RESET = socket_regs_pkg::ID_REV_RESET,
    parameter logic [3:0] REV_LEGACY = socket_regs_pkg::ID_REV_LEGACY
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,

    // Register access port
    input wire logic i_acc_mem_space,
    input wire logic i_acc_socket,
    input wire logic [11:0] i_acc_addr,
    input wire logic i_acc_wr,
    input wire logic i_acc_rd,
    input wire logic [7:0] i_acc_wdata,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,

    // Settings from neighbouring registers
    input wire logic i_id_write_unlock,
    input wire logic [NUM_SOCKETS-1:0] i_socket_power_on,
    input wire logic [NUM_SOCKETS-1:0] i_io_card,

    // Card pins, one bit per socket
    input wire logic [NUM_SOCKETS-1:0] i_card_ready,
    input wire logic [NUM_SOCKETS-1:0] i_card_write_protect,
    input wire logic [NUM_SOCKETS-1:0] i_card_detect_one_n,
    input wire logic [NUM_SOCKETS-1:0] i_card_detect_two_n,
    input wire logic [NUM_SOCKETS-1:0] i_card_bvd1_stschg,
    input wire logic [NUM_SOCKETS-1:0] i_card_bvd2_spkr,

    // Per-socket state
    output logic [NUM_SOCKETS-1:0] o_compat_mode,
    output logic [NUM_SOCKETS-1:0] o_battery_dead,
    output logic [NUM_SOCKETS-1:0] o_battery_low
);

    // =========================================================
    // Decode helpers
    function automatic socket_regs_pkg::reg_sel_t decode_sel(
        input logic mem,
        input logic [11:0] a
    );
        socket_regs_pkg::reg_sel_t sel;
        sel = socket_regs_pkg::SEL_NONE;
        if (mem) begin
            if (a == socket_regs_pkg::MEM_ID_OFS) begin
                sel = socket_regs_pkg::SEL_ID;
            end else if (a == socket_regs_pkg::MEM_STAT_OFS) begin
                sel = socket_regs_pkg::SEL_STAT;
            end
        end else if (a[11:8] == socket_regs_pkg::IDX_HIGH_ZERO) begin
            if (a[7:0] == socket_regs_pkg::IDX_ID_A ||
                a[7:0] == socket_regs_pkg::IDX_ID_B) begin
                sel = socket_regs_pkg::SEL_ID;
            end else if (a[7:0] == socket_regs_pkg::IDX_STAT_A ||
                a[7:0] == socket_regs_pkg::IDX_STAT_B) begin
                sel = socket_regs_pkg::SEL_STAT;
            end
        end
        return sel;
    endfunction

    function automatic logic decode_sock(
        input logic mem,
        input logic sock,
        input logic [11:0] a
    );
        logic b;
        b = 1'b0;
        if (mem) begin
            b = sock;
        end else begin
            b = (a[7:0] == socket_regs_pkg::IDX_ID_B) ||
                (a[7:0] == socket_regs_pkg::IDX_STAT_B);
        end
        return b;
    endfunction

    // Returns {dead, low} for a memory card battery field
    function automatic logic [1:0] batt_decode(
        input logic [1:0] code
    );
        logic [1:0] r;
        r = 2'b00;
        if (code == socket_regs_pkg::BATT_GOOD) begin
            r = 2'b00;
        end else if (code == socket_regs_pkg::BATT_WARN) begin
            r = 2'b01;
        end else begin
            r = 2'b10;
        end
        return r;
    endfunction

    // =========================================================
    // Access decode
    socket_regs_pkg::reg_sel_t acc_sel;
    logic acc_sock;

    always_comb begin
        acc_sel = decode_sel(i_acc_mem_space, i_acc_addr);
        acc_sock = decode_sock(i_acc_mem_space, i_acc_socket,
            i_acc_addr);
    end

    // =========================================================
    // Per-socket registers
    logic [7:0] id_view [NUM_SOCKETS];
    logic [7:0] stat_view [NUM_SOCKETS];
    logic [NUM_SOCKETS-1:0] compat_r;
    logic [NUM_SOCKETS-1:0] batt_dead_r;
    logic [NUM_SOCKETS-1:0] batt_low_r;

    genvar s;
    generate
        for (s = 0; s < NUM_SOCKETS; s++) begin : g_sock
            logic [5:0] pins_raw;
            logic [5:0] pins_sync;
            logic [5:0] stat_pins;
            logic [1:0] batt_flags;
            logic [1:0] emu_r;
            logic [3:0] rev_r;
            logic [1:0] stat_top_r;
            logic [5:0] stat_low_r;
            logic id_wr;

            // Raw levels only; no logic before the synchroniser
            always_comb begin
                pins_raw[socket_regs_pkg::PIN_BVD1] =
                    i_card_bvd1_stschg[s];
                pins_raw[socket_regs_pkg::PIN_BVD2] =
                    i_card_bvd2_spkr[s];
                pins_raw[socket_regs_pkg::PIN_CD1] =
                    i_card_detect_one_n[s];
                pins_raw[socket_regs_pkg::PIN_CD2] =
                    i_card_detect_two_n[s];
                pins_raw[socket_regs_pkg::PIN_WP] =
                    i_card_write_protect[s];
                pins_raw[socket_regs_pkg::PIN_READY] =
                    i_card_ready[s];
            end

            socket_pin_sampler #(
                .WIDTH(socket_regs_pkg::STAT_PINS_W)
            ) u_sampler (
                .i_ref_clk(i_ref_clk),
                .i_pins(pins_raw),
                .o_pins(pins_sync)
            );

            // Detect pins are active low; status bits read one on low
            always_comb begin
                stat_pins = pins_sync;
                stat_pins[socket_regs_pkg::PIN_CD1] =
                    ~pins_sync[socket_regs_pkg::PIN_CD1];
                stat_pins[socket_regs_pkg::PIN_CD2] =
                    ~pins_sync[socket_regs_pkg::PIN_CD2];
            end

            // Only accepted while the unlock bit is set
            // Socket match on one bit: two sockets at most
            assign id_wr = i_acc_wr && i_id_write_unlock &&
                (acc_sel == socket_regs_pkg::SEL_ID) &&
                (acc_sock == 1'(s));

            // =================================================
            // Identity storage
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    emu_r <= socket_regs_pkg::ID_EMU_RESET;
                end else if (id_wr) begin
                    emu_r <= i_acc_wdata[5:4];
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    rev_r <= REV_RESET;
                end else if (id_wr) begin
                    rev_r <= i_acc_wdata[3:0];
                end
            end

            // Mode follows the last revision code written
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    compat_r[s] <= 1'b0;
                end else if (id_wr) begin
                    compat_r[s] <= (i_acc_wdata[3:0] == REV_LEGACY);
                end
            end

            always_comb begin
                id_view[s] = {socket_regs_pkg::IFACE_TYPE_IO_MEM,
                    emu_r, rev_r};
            end

            // =================================================
            // Interface status
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    stat_top_r <= socket_regs_pkg::STAT_TOP_RESET;
                end else begin
                    stat_top_r <= {1'b0, i_socket_power_on[s]};
                end
            end

            // Loads during reset too, so pins show straight away
            always_ff @(posedge i_ref_clk) begin
                stat_low_r <= stat_pins;
            end

            always_comb begin
                stat_view[s] = {stat_top_r, stat_low_r};
            end

            // =================================================
            // Battery decode, memory cards only
            // Works on the registered field; flags flop one edge behind status
            always_comb begin
                batt_flags = batt_decode(stat_low_r[1:0]);
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    batt_dead_r[s] <= 1'b0;
                end else if (i_io_card[s]) begin
                    // Raw speaker and status-change levels
                    batt_dead_r[s] <= 1'b0;
                end else begin
                    batt_dead_r[s] <= batt_flags[1];
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    batt_low_r[s] <= 1'b0;
                end else if (i_io_card[s]) begin
                    batt_low_r[s] <= 1'b0;
                end else begin
                    batt_low_r[s] <= batt_flags[0];
                end
            end
        end
    endgenerate

    // =========================================================
    // Read path
    logic [7:0] rd_mux;

    // Bits one and zero carry the pins unchanged for either card
    // type; only the side outputs interpret them.
    always_comb begin
        rd_mux = 8'h00;
        case (acc_sel)
            socket_regs_pkg::SEL_ID: begin
                rd_mux = id_view[acc_sock];
            end
            socket_regs_pkg::SEL_STAT: begin
                rd_mux = stat_view[acc_sock];
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // Reads change no state; status writes fall through unused
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
        end else if (i_acc_rd) begin
            o_rd_data <= rd_mux;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_acc_rd;
        end
    end

    // =========================================================
    // Side outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_compat_mode <= '0;
        end else begin
            o_compat_mode <= compat_r;
        end
    end

    // Registered once more so every output leaves a flop
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_battery_dead <= '0;
        end else begin
            o_battery_dead <= batt_dead_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_battery_low <= '0;
        end else begin
            o_battery_low <= batt_low_r;
        end
    end

endmodule

`default_nettype wire

// ==== testbench/socket_regs_assertions.sv ====
// Checker for the socket identity and status registers.
// Assumes it is bound to the register block's ports.
`timescale 1ns/1ps
`default_nettype none
module socket_regs_assertions #(
    parameter int NUM_SOCKETS = 2,
    parameter logic [3:0] REV_LEGACY = 4'h3
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_acc_mem_space,
    input wire logic [11:0] i_acc_addr,
    input wire logic i_acc_wr,
    input wire logic i_acc_rd,
    input wire logic [7:0] i_acc_wdata,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic i_id_write_unlock,
    input wire logic [NUM_SOCKETS-1:0] i_io_card,
    input wire logic [NUM_SOCKETS-1:0] o_compat_mode,
    input wire logic [NUM_SOCKETS-1:0] o_battery_dead,
    input wire logic [NUM_SOCKETS-1:0] o_battery_low
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ==========================================
    // Index-space identity write, socket A
    logic id_a;
    assign id_a = !i_acc_mem_space && i_acc_addr == 12'h000;
    // ==========================================
    // Properties
    AST_RD_PULSE: assert property (i_acc_rd |=> o_rd_valid)
        else $error("read not answered");
    AST_RD_QUIET: assert property (!i_acc_rd |=> !o_rd_valid
        && $stable(o_rd_data)) else $error("read data moved");
    AST_ID_TYPE: assert property (i_acc_rd && i_acc_mem_space
        && i_acc_addr == 12'h800 |=> o_rd_data[7:6] == 2'b10)
        else $error("type field wrong");
    AST_STAT_MSB: assert property (i_acc_rd && i_acc_mem_space
        && i_acc_addr == 12'h801 |=> !o_rd_data[7])
        else $error("status top bit set");
    AST_UNMAPPED: assert property (i_acc_rd && !i_acc_mem_space
        && i_acc_addr == 12'h002 |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_LEGACY: assert property (i_acc_wr && id_a && i_id_write_unlock
        && i_acc_wdata[3:0] == REV_LEGACY |-> ##2 o_compat_mode[0])
        else $error("legacy mode not entered");
    AST_LOCKED: assert property (i_acc_wr && id_a && !i_id_write_unlock
        && !$past(i_acc_wr) |-> ##2 $stable(o_compat_mode))
        else $error("locked write took effect");
    AST_BATT_EXCL: assert property (!(o_battery_dead[0]
        && o_battery_low[0])) else $error("battery dead and low");
    AST_BATT_IO: assert property (i_io_card[0] [*5] |=>
        !o_battery_dead[0] && !o_battery_low[0])
        else $error("battery decode on io card");
endmodule
bind socket_id_status_regs socket_regs_assertions #(
    .NUM_SOCKETS(NUM_SOCKETS),
    .REV_LEGACY(REV_LEGACY)
) socket_regs_assertions_inst (.*);
`default_nettype wire

// ==== testbench/card_socket_model.sv ====
// Behavioural 16-bit card sitting in one socket.
// Assumes the bench commands its contacts and pin levels.
`timescale 1ns/1ps
`default_nettype none
module card_socket_model (
    // Commanded card state
    input wire logic [1:0] i_seat,
    input wire logic i_ready,
    input wire logic i_wp,
    input wire logic [1:0] i_bvd,
    // Socket pins
    output logic o_cd1_n,
    output logic o_cd2_n,
    output logic o_ready,
    output logic o_wp,
    output logic o_bvd1,
    output logic o_bvd2
);
    // ==========================================
    // Contacts close one by one on a tilted card
    assign o_cd1_n = !i_seat[0];
    assign o_cd2_n = !i_seat[1];
    // Empty socket: pull-ups take signal pins high
    logic empty;
    assign empty = i_seat == 2'b00;
    assign o_ready = empty | i_ready;
    assign o_wp = empty | i_wp;
    assign o_bvd1 = empty | i_bvd[0];
    assign o_bvd2 = empty | i_bvd[1];
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the socket identity and status registers.
// Assumes the card model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0] RV = socket_regs_pkg::ID_REV_RESET;
    localparam logic [3:0] LG = socket_regs_pkg::ID_REV_LEGACY;
    logic clk = 1'b0;
    logic rst, mem, sock, wr, rd, unlock, rvalid;
    logic [11:0] addr;
    logic [7:0] wdata, rdata;
    logic [1:0] pwr, io, rdy, wp, compat, dead, low;
    logic [1:0] seat [2];
    logic [1:0] bvd [2];
    wire [1:0] cd1_n, cd2_n, p_rdy, p_wp, b1, b2;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    // ==========================================
    // Cards and design
    for (genvar g = 0; g < 2; g++) begin : g_sock
        card_socket_model card_socket_model_inst (
            .i_seat(seat[g]), .i_ready(rdy[g]), .i_wp(wp[g]),
            .i_bvd(bvd[g]), .o_cd1_n(cd1_n[g]), .o_cd2_n(cd2_n[g]),
            .o_ready(p_rdy[g]), .o_wp(p_wp[g]), .o_bvd1(b1[g]),
            .o_bvd2(b2[g]));
    end
    socket_id_status_regs socket_id_status_regs_inst (
        .i_ref_clk(clk), .i_rst(rst), .i_acc_mem_space(mem),
        .i_acc_socket(sock), .i_acc_addr(addr), .i_acc_wr(wr),
        .i_acc_rd(rd), .i_acc_wdata(wdata), .o_rd_data(rdata),
        .o_rd_valid(rvalid), .i_id_write_unlock(unlock),
        .i_socket_power_on(pwr), .i_io_card(io), .i_card_ready(p_rdy),
        .i_card_write_protect(p_wp), .i_card_detect_one_n(cd1_n),
        .i_card_detect_two_n(cd2_n), .i_card_bvd1_stschg(b1),
        .i_card_bvd2_spkr(b2), .o_compat_mode(compat),
        .o_battery_dead(dead), .o_battery_low(low));
    // ==========================================
    // Clock and hang guard
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ==========================================
    // Access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic m, s, input logic [11:0] a,
                          input logic [7:0] e);
        @(negedge clk);
        {mem, sock, addr, rd} = {m, s, a, 1'b1};
        @(negedge clk);
        rd = 0;
        chk({7'h0, rvalid}, 8'h01);
        chk(rdata, e);
    endtask
    task automatic wr_do(input logic m, s, input logic [11:0] a,
                         input logic [7:0] d);
        @(negedge clk);
        {mem, sock, addr, wdata, wr} = {m, s, a, d, 1'b1};
        @(negedge clk);
        wr = 0;
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {rd, wr, mem, sock, addr, wdata, unlock, io} = '0;
        rst = 1'b1;
        {pwr, rdy, wp} = 6'b01_01_00;
        seat[0] = 2'b11;
        seat[1] = 2'b00;
        bvd[0] = 2'b11;
        bvd[1] = 2'b00;
        repeat (5) @(negedge clk);
        rst = 0;
        rd_chk(1, 0, 12'h801, 8'h6f);
        rd_chk(0, 0, 12'h041, 8'h33);
        rd_chk(1, 0, 12'h800, {4'h8, RV});
        rd_chk(0, 0, 12'h040, {4'h8, RV});
        wr_do(0, 0, 12'h000, 8'h3f);
        rd_chk(0, 0, 12'h000, {4'h8, RV});
        unlock = 1;
        wr_do(0, 0, 12'h000, {4'hf, LG});
        rd_chk(1, 0, 12'h800, {4'hb, LG});
        chk({6'h0, compat}, 8'h01);
        wr_do(1, 1, 12'h800, 8'h1a);
        rd_chk(0, 0, 12'h040, 8'h9a);
        wr_do(0, 0, 12'h000, 8'h05);
        wr_do(0, 0, 12'h001, 8'hff);
        rd_chk(0, 0, 12'h001, 8'h6f);
        chk({6'h0, compat}, 8'h00);
        rd_chk(0, 0, 12'h002, 8'h00);
        rd_chk(0, 0, 12'h100, 8'h00);
        wr_do(0, 1, 12'h040, {4'h0, LG});
        rd_chk(1, 1, 12'h800, {4'h8, LG});
        chk({6'h0, compat}, 8'h02);
        // Sweep every battery code on memory and io cards
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            {io[0], pwr[0], rdy[0], wp[0]} = {i[2], i[0], i[1], i[2]};
            seat[0] = {i[2], 1'b1};
            bvd[0] = i[1:0];
            repeat (6) @(negedge clk);
            rd_chk(0, 0, 12'h001, {1'b0, i[0], i[1], i[2], i[2], 1'b1,
                i[1:0]});
            chk({4'h0, dead, low}, {5'h0, !i[2] && !i[1], 1'b0,
                !i[2] && i[1:0] == 2'b10});
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
